// File: pkg/cyc_timer_pkg.sv
/*
 * Constants for the cyclic sense and cyclic wake timer: APB register map,
 * field positions, reset values and timing counts.
 * Assumes a 50 MHz reference clock.
 */
package cyc_timer_pkg;
    // Register byte offsets.
    localparam logic [7:0] OFF_TIMER_CTRL = 8'h00;
    localparam logic [7:0] OFF_WAKE_CTRL = 8'h04;
    localparam logic [7:0] OFF_WAKE_STAT_A = 8'h08;
    localparam logic [7:0] OFF_WAKE_STAT_B = 8'h0C;
    localparam logic [7:0] OFF_LEVEL_STAT = 8'h10;
    localparam logic [7:0] OFF_MODE_CTRL = 8'h14;
    localparam logic [7:0] OFF_DEV_STAT = 8'h18;
    // Timer control fields.
    localparam int PERIOD_LSB = 0;
    localparam int ONTIME_LSB = 4;
    // Wake control fields.
    localparam int WK_EN_BIT = 0;
    localparam int TIMER_WK_EN_BIT = 1;
    localparam int HS_CFG_LSB = 4;
    localparam logic [2:0] HS_CFG_CYCLIC = 3'h3;
    // Status A: bit 0 wake input event, bit 1 timer event.
    localparam int WK_FLAG_BIT = 0;
    localparam int TMR_FLAG_BIT = 1;
    // Status B: bit 0 command error, bit 1 switch fault.
    localparam int CMD_ERR_BIT = 0;
    localparam int HS_FAULT_BIT = 1;
    // On-time codes.
    localparam logic [2:0] ON_OFF = 3'h0;
    localparam logic [2:0] ON_0P1MS = 3'h1;
    localparam logic [2:0] ON_OFF_HIGH = 3'h6;
    localparam logic [2:0] ON_OFF_LOW = 3'h7;
    localparam logic [31:0] RESET_VALUE = 32'h0000_0000;
    // Time base: one tick every 0.1 ms.
    localparam int CLK_HZ = 50_000_000;
    localparam int TICK_US = 100;
    localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
    // Filter time after on window.
    localparam int FILTER_US = 16;
    localparam int FILTER_CYCLES = (CLK_HZ / 1_000_000) * FILTER_US;
    typedef enum logic [1:0] {
        MODE_NORMAL,
        MODE_STOP,
        MODE_SLEEP,
        MODE_FAILSAFE
    } sbc_mode_t;
endpackage : cyc_timer_pkg

// File: verilog/tick_divider.sv
/*
 * Prescaler producing a one-cycle tick every 0.1 ms.
 * Assumes the reference clock set in the package.
 */
`timescale 1ns/1ns
`default_nettype none
module tick_divider
    import cyc_timer_pkg::*;
#(
    parameter int DIV = TICK_CYCLES
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst_n,
    // Clears the phase so a restart begins a fresh tick.
    input wire logic clear,
    // Tick out.
    output logic tick
);
    logic [15:0] cnt_r;

    if (DIV < 1 || DIV > 65535) begin
        $error("DIV out of range");
    end

    // Free-running count, restarted on clear.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 16'h0000;
        end else if (clear || cnt_r == 16'(DIV - 1)) begin
            cnt_r <= 16'h0000;
        end else begin
            cnt_r <= cnt_r + 16'h0001;
        end
    end

    assign tick = !clear && cnt_r == 16'(DIV - 1);
endmodule : tick_divider
`default_nettype wire

// File: verilog/sense_sync.sv
/*
 * Three-stage synchroniser for the wake sense pin; the output changes once the
 * second and third stages agree.
 * Assumes an asynchronous pin.
 */
`timescale 1ns/1ns
`default_nettype none
module sense_sync (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst_n,
    // Pin and clean level.
    input wire logic pinIn,
    output logic level
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic level_r;

    // The first stage is read only by the second, to contain metastability.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
            level_r <= 1'b0;
        end else begin
            s1_r <= pinIn;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                level_r <= s3_r;
            end
        end
    end

    assign level = level_r;
endmodule : sense_sync
`default_nettype wire

// File: verilog/cyclic_sense_wake_timer.sv
/*
 * Cyclic sense and cyclic wake timer with APB register access. Pulses the
 * high-side switch, samples the wake sense pin, raises interrupts or requests
 * a restart from sleep.
 * Assumes an external mode controller supplies the current mode and takes the
 * restart request; fault inputs are synchronous to ref_clk.
 */
`timescale 1ns/1ns
`default_nettype none
module cyclic_sense_wake_timer
    import cyc_timer_pkg::*;
#(
    parameter int TICK_DIV = TICK_CYCLES,
    parameter int FILTER_LEN = FILTER_CYCLES
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst_n,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Mode controller.
    input wire sbc_mode_t sbcMode,
    input wire logic restartMode,
    input wire logic sleepRequest,
    output logic restartRequest,
    output logic reset_out_n,
    output logic main_supply_out,
    // Pins and faults.
    input wire logic wake_sense_input,
    input wire logic hsOvercurrent,
    input wire logic severe_overtemp,
    output logic high_side_switch,
    output logic staticSense,
    output logic interrupt_out_n
);
    // Period table in 0.1 ms ticks, codes ascending.
    function automatic logic [23:0] periodTicks(input logic [3:0] code);
        unique case (code)
            4'h0: periodTicks = 24'd100;
            4'h1: periodTicks = 24'd200;
            4'h2: periodTicks = 24'd500;
            4'h3: periodTicks = 24'd1000;
            4'h4: periodTicks = 24'd2000;
            4'h5: periodTicks = 24'd5000;
            4'h6: periodTicks = 24'd10000;
            4'h7: periodTicks = 24'd20000;
            4'h8: periodTicks = 24'd50000;
            4'h9: periodTicks = 24'd100000;
            4'hA: periodTicks = 24'd200000;
            4'hB: periodTicks = 24'd500000;
            4'hC: periodTicks = 24'd1000000;
            4'hD: periodTicks = 24'd2000000;
            4'hE: periodTicks = 24'd5000000;
            4'hF: periodTicks = 24'd10000000;
        endcase
    endfunction : periodTicks

    // On-time table in 0.1 ms ticks; off codes give zero.
    function automatic logic [23:0] onTicks(input logic [2:0] code);
        unique case (code)
            3'h1: onTicks = 24'd1;
            3'h2: onTicks = 24'd3;
            3'h3: onTicks = 24'd10;
            3'h4: onTicks = 24'd100;
            3'h5: onTicks = 24'd200;
            default: onTicks = 24'd0;
        endcase
    endfunction : onTicks

    if (FILTER_LEN < 1 || FILTER_LEN > 65535) begin
        $error("FILTER_LEN out of range");
    end

    logic [3:0] periodCode_r;
    logic [2:0] onCode_r;
    logic wkEn_r;
    logic timerWkEn_r;
    logic [2:0] hsCfg_r;
    logic wkFlag_r;
    logic tmrFlag_r;
    logic cmdErr_r;
    logic hsFault_r;
    logic levelStat_r;
    logic running_r;
    logic firstWindow_r;
    logic haveRef_r;
    logic refLevel_r;
    logic [23:0] phase_r;
    logic inFilter_r;
    logic [15:0] filtCnt_r;
    logic filtLevel_r;
    logic filtStable_r;
    logic wakeIrq_r;
    logic restart_r;
    logic [31:0] prdata_r;
    logic tick;
    logic senseLevel;
    logic wrEn;
    logic onWrite;
    logic sampleOk;
    logic onActive;
    logic windowStart;
    logic windowEnd;
    logic senseMode;
    logic lowPowerOk;
    logic senseWake;
    logic timerWake;
    logic clrA;
    logic clrB;

    assign wrEn = psel && penable && pwrite;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign prdata = prdata_r;

    // Writing a non-off on-time code starts the timer.
    assign onWrite = wrEn && paddr == OFF_TIMER_CTRL && onTicks(pwdata[ONTIME_LSB +: 3]) != 24'd0;
    assign senseMode = hsCfg_r == HS_CFG_CYCLIC;
    assign onActive = running_r && phase_r < onTicks(onCode_r);
    assign windowStart = running_r && tick && phase_r == 24'd0;
    assign windowEnd = running_r && tick && phase_r == onTicks(onCode_r) - 24'd1;
    // In Stop, sense updates only for the shortest on-time.
    assign lowPowerOk = sbcMode != MODE_STOP || onCode_r == ON_0P1MS;

    tick_divider #(
        .DIV(TICK_DIV)
    ) u_tick (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .clear(restartMode),
        .tick(tick)
    );

    sense_sync u_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .pinIn(wake_sense_input),
        .level(senseLevel)
    );

    // Configuration registers.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            periodCode_r <= RESET_VALUE[3:0];
            onCode_r <= ON_OFF;
            wkEn_r <= 1'b0;
            timerWkEn_r <= 1'b0;
            hsCfg_r <= 3'h0;
        end else if (wrEn && paddr == OFF_TIMER_CTRL) begin
            periodCode_r <= pwdata[PERIOD_LSB +: 4];
            onCode_r <= pwdata[ONTIME_LSB +: 3];
        end else if (wrEn && paddr == OFF_WAKE_CTRL) begin
            wkEn_r <= pwdata[WK_EN_BIT];
            timerWkEn_r <= pwdata[TIMER_WK_EN_BIT];
            hsCfg_r <= pwdata[HS_CFG_LSB +: 3];
        end
    end

    // Timer phase; cleared by restart or by a write that starts the timer, never by a switch fault.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            running_r <= 1'b0;
            phase_r <= 24'd0;
            firstWindow_r <= 1'b0;
        end else if (restartMode) begin
            running_r <= 1'b0;
            phase_r <= 24'd0;
            firstWindow_r <= 1'b0;
        end else if (onWrite) begin
            running_r <= 1'b1;
            phase_r <= 24'd0;
            firstWindow_r <= 1'b1;
        end else if (wrEn && paddr == OFF_TIMER_CTRL) begin
            running_r <= 1'b0;
        end else if (running_r && tick) begin
            phase_r <= (phase_r >= periodTicks(periodCode_r) - 24'd1) ? 24'd0 : phase_r + 24'd1;
            if (windowStart) begin
                firstWindow_r <= 1'b0;
            end
        end
    end

    // Switch drive; off in fail-safe, at once on a fault, and until its flag is cleared.
    assign high_side_switch = senseMode && onActive && !hsFault_r && !hsOvercurrent && !severe_overtemp
        && sbcMode != MODE_FAILSAFE;
    assign staticSense = !senseMode || !running_r || hsFault_r || sbcMode == MODE_FAILSAFE;

    // Fault latch; the timer keeps running while the switch is held off.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            hsFault_r <= 1'b0;
        end else if ((hsOvercurrent || severe_overtemp) && senseMode && sbcMode != MODE_FAILSAFE) begin
            hsFault_r <= 1'b1;
        end else if (clrB && pwdata[HS_FAULT_BIT]) begin
            hsFault_r <= 1'b0;
        end
    end

    // Filter: the level must hold for the whole filter time.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            inFilter_r <= 1'b0;
            filtCnt_r <= 16'h0000;
            filtLevel_r <= 1'b0;
            filtStable_r <= 1'b0;
        end else if (windowEnd && senseMode && !hsFault_r) begin
            inFilter_r <= 1'b1;
            filtCnt_r <= 16'h0000;
            filtLevel_r <= senseLevel;
            filtStable_r <= 1'b1;
        end else if (inFilter_r) begin
            if (senseLevel != filtLevel_r) begin
                filtStable_r <= 1'b0;
            end
            if (filtCnt_r == 16'(FILTER_LEN - 1)) begin
                inFilter_r <= 1'b0;
            end else begin
                filtCnt_r <= filtCnt_r + 16'h0001;
            end
        end
    end

    // A sample is taken when the filter time completes.
    assign sampleOk = inFilter_r && filtCnt_r == 16'(FILTER_LEN - 1) && filtStable_r && senseLevel == filtLevel_r;
    assign senseWake = sampleOk && haveRef_r && filtLevel_r != refLevel_r && wkEn_r;
    assign timerWake = windowStart && !firstWindow_r && timerWkEn_r;

    // Reference level; learning restarts on restart, or on a timer start in the cyclic sense configuration.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            haveRef_r <= 1'b0;
            refLevel_r <= 1'b0;
        end else if (restartMode || (onWrite && senseMode)) begin
            haveRef_r <= 1'b0;
        end else if (sampleOk) begin
            haveRef_r <= 1'b1;
            refLevel_r <= filtLevel_r;
        end
    end

    // Level status tracks samples only in Normal or Stop.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            levelStat_r <= 1'b0;
        end else if (sampleOk && (sbcMode == MODE_NORMAL || sbcMode == MODE_STOP) && lowPowerOk) begin
            levelStat_r <= filtLevel_r;
        end
    end

    assign clrA = wrEn && paddr == OFF_WAKE_STAT_A;
    assign clrB = wrEn && paddr == OFF_WAKE_STAT_B;

    // Sticky wake flags, write one to clear; a new event wins over the clear.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wkFlag_r <= 1'b0;
            tmrFlag_r <= 1'b0;
        end else begin
            if (senseWake && lowPowerOk) begin
                wkFlag_r <= 1'b1;
            end else if (clrA && pwdata[WK_FLAG_BIT]) begin
                wkFlag_r <= 1'b0;
            end
            if (timerWake) begin
                tmrFlag_r <= 1'b1;
            end else if (clrA && pwdata[TMR_FLAG_BIT]) begin
                tmrFlag_r <= 1'b0;
            end
        end
    end

    // Command error when on-time exceeds the period.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmdErr_r <= 1'b0;
        end else if (onTicks(onCode_r) > periodTicks(periodCode_r)) begin
            cmdErr_r <= 1'b1;
        end else if (clrB && pwdata[CMD_ERR_BIT]) begin
            cmdErr_r <= 1'b0;
        end
    end

    // Interrupt pulse in Normal/Stop, even if the flag was already set.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wakeIrq_r <= 1'b0;
        end else begin
            wakeIrq_r <= ((senseWake && lowPowerOk) || timerWake)
                && (sbcMode == MODE_NORMAL || sbcMode == MODE_STOP);
        end
    end
    assign interrupt_out_n = !wakeIrq_r;

    // Restart request from Sleep: wake events, bad sleep entries, lost source.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            restart_r <= 1'b0;
        end else if (restartMode) begin
            restart_r <= 1'b0;
        end else if (sbcMode == MODE_SLEEP && (senseWake || timerWake)) begin
            restart_r <= 1'b1;
        end else if (sleepRequest && (wkFlag_r || tmrFlag_r || cmdErr_r || hsFault_r)) begin
            restart_r <= 1'b1;
        end else if (sleepRequest && wkEn_r && !timerWkEn_r && senseMode && !running_r) begin
            restart_r <= 1'b1;
        end else if (sbcMode == MODE_SLEEP && hsFault_r && wkEn_r && senseMode && !timerWkEn_r) begin
            restart_r <= 1'b1;
        end
    end
    assign restartRequest = restart_r;
    assign reset_out_n = !(restart_r || restartMode);
    assign main_supply_out = sbcMode != MODE_SLEEP || restart_r;

    // Read data mux; unmapped addresses read zero.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata_r <= RESET_VALUE;
        end else if (psel && !penable && !pwrite) begin
            unique case (paddr)
                OFF_TIMER_CTRL: prdata_r <= {25'h0, onCode_r, periodCode_r};
                OFF_WAKE_CTRL: prdata_r <= {25'h0, hsCfg_r, 2'h0, timerWkEn_r, wkEn_r};
                OFF_WAKE_STAT_A: prdata_r <= {30'h0, tmrFlag_r, wkFlag_r};
                OFF_WAKE_STAT_B: prdata_r <= {30'h0, hsFault_r, cmdErr_r};
                OFF_LEVEL_STAT: prdata_r <= {31'h0, levelStat_r};
                OFF_DEV_STAT: prdata_r <= {29'h0, onActive, haveRef_r, running_r};
                default: prdata_r <= RESET_VALUE;
            endcase
        end
    end
endmodule : cyclic_sense_wake_timer
`default_nettype wire

// File: test/cyclic_sense_wake_timer_assertions.sv
/* Port checker for the cyclic sense and wake timer.
   Assumes binding to the top module; the bench is the mode controller. */
`timescale 1ns/1ns
`default_nettype none
module cyclic_sense_wake_timer_assertions
    import cyc_timer_pkg::*;
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst_n,
    // Mode controller.
    input wire sbc_mode_t sbcMode,
    input wire logic restartMode,
    input wire logic restartRequest,
    input wire logic reset_out_n,
    input wire logic main_supply_out,
    // Pins and faults.
    input wire logic hsOvercurrent,
    input wire logic severe_overtemp,
    input wire logic high_side_switch,
    input wire logic staticSense,
    input wire logic interrupt_out_n
);
    // All checks use the reference clock and rest while reset is low.
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    AST_FAILSAFE_OFF: assert property (sbcMode == MODE_FAILSAFE |-> !high_side_switch && staticSense)
        else $error("fail-safe switch or sensing");
    AST_FAULT_OFF: assert property (hsOvercurrent || severe_overtemp |-> !high_side_switch)
        else $error("switch on in fault");
    AST_INT_PULSE: assert property ($fell(interrupt_out_n) |=> interrupt_out_n)
        else $error("interrupt too long");
    AST_INT_NOT_SLEEP: assert property (!interrupt_out_n |-> $past(sbcMode) != MODE_SLEEP)
        else $error("interrupt in sleep");
    AST_RST_FOLLOWS: assert property (restartRequest || restartMode |-> !reset_out_n)
        else $error("reset output high");
    AST_SUPPLY_UP: assert property (sbcMode != MODE_SLEEP || restartRequest |-> main_supply_out)
        else $error("supply off awake");
    AST_SUPPLY_DOWN: assert property (sbcMode == MODE_SLEEP && !restartRequest |-> !main_supply_out)
        else $error("supply on asleep");
    AST_REQ_HOLD: assert property (restartRequest && !restartMode |=> restartRequest)
        else $error("request dropped");
    AST_REQ_CLEAR: assert property (restartMode ##1 restartMode |-> !restartRequest)
        else $error("request kept");
endmodule : cyclic_sense_wake_timer_assertions
bind cyclic_sense_wake_timer cyclic_sense_wake_timer_assertions u_checker (.*);
`default_nettype wire

// File: test/switch_network.sv
/* Model of the external switch network fed by the high-side output.
   Assumes a pull-down on the wake pin and a small input capacitance. */
`timescale 1ns/1ns
`default_nettype none
module switch_network #(
    parameter int HOLD = 12
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst_n,
    // Supply from the block and the contact state.
    input wire logic high_side_switch,
    input wire logic switchClosed,
    // Wake pin.
    output logic wake_sense_input
);
    int holdCnt;
    logic lastLvl;
    // The capacitance keeps the last level for HOLD cycles after the supply goes.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            holdCnt <= 0;
            lastLvl <= 1'b0;
        end else if (high_side_switch) begin
            holdCnt <= HOLD;
            lastLvl <= switchClosed;
        end else if (holdCnt > 0) begin
            holdCnt <= holdCnt - 1;
        end
    end
    // Without supply and once the charge is gone the pull-down wins.
    assign wake_sense_input = high_side_switch ? switchClosed : (holdCnt > 0 && lastLvl);
endmodule : switch_network
`default_nettype wire

// File: test/cyclic_sense_wake_timer_tb.sv
/* Self-checking bench for the cyclic sense and wake timer.
   Assumes shortened tick and filter counts; the bench plays APB master and mode controller. */
`timescale 1ns/1ns
`default_nettype none
module cyclic_sense_wake_timer_tb
    import cyc_timer_pkg::*;
;
    localparam int TDIV = 10;
    localparam int PER = 100 * TDIV;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, restartRequest, reset_out_n, main_supply_out;
    sbc_mode_t sbcMode = MODE_NORMAL;
    logic restartMode = 1'b0;
    logic sleepRequest = 1'b0;
    logic hsOvercurrent = 1'b0;
    logic severe_overtemp = 1'b0;
    logic switchClosed = 1'b0;
    logic wake_sense_input, high_side_switch, staticSense, interrupt_out_n;
    int num_errors = 0;
    int compares = 0;
    int hs, ints;

    // Free-running 50 MHz clock.
    always #10 ref_clk = ~ref_clk;

    cyclic_sense_wake_timer #(.TICK_DIV(TDIV), .FILTER_LEN(4)) u_cyclic_sense_wake_timer (.ref_clk(ref_clk),
        .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .sbcMode(sbcMode), .restartMode(restartMode),
        .sleepRequest(sleepRequest), .restartRequest(restartRequest), .reset_out_n(reset_out_n),
        .main_supply_out(main_supply_out), .wake_sense_input(wake_sense_input), .hsOvercurrent(hsOvercurrent),
        .severe_overtemp(severe_overtemp), .high_side_switch(high_side_switch), .staticSense(staticSense),
        .interrupt_out_n(interrupt_out_n));
    switch_network u_switch_network (.ref_clk(ref_clk), .rst_n(rst_n),
        .high_side_switch(high_side_switch), .switchClosed(switchClosed), .wake_sense_input(wake_sense_input));

    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish

    task automatic check(input string w, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", w, e, g);
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : cyc

    // One APB transfer; the request stands until pready is seen at an edge.
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        check("pready pslverr", 32'h0000_0001, 32'({pslverr, pready}));
        if (n >= 20) tally_and_finish();
    endtask : apb

    task automatic rdchk(input string w, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(a, 1'b0, 32'h0000_0000);
        check(w, e, rd & m);
    endtask : rdchk

    // Waits for an interrupt (0), a restart request (1) or the switch (2).
    task automatic waitFor(input int s, input int lim, input string w);
        int n;
        n = 0;
        while (n < lim && !(s == 0 ? interrupt_out_n === 1'b0 : s == 1 ? restartRequest === 1'b1 :
               high_side_switch === 1'b1)) begin
            @(posedge ref_clk);
            n++;
        end
        check(w, 32'h0000_0001, 32'(n < lim));
        if (n >= lim) tally_and_finish();
    endtask : waitFor

    // Counts switch-on cycles and interrupt pulses over n cycles.
    task automatic watch(input int n);
        hs = 0;
        ints = 0;
        repeat (n) begin
            @(posedge ref_clk);
            hs += (high_side_switch === 1'b1);
            ints += (interrupt_out_n === 1'b0);
        end
    endtask : watch

    task automatic sleep();
        sbcMode <= MODE_SLEEP;
        sleepRequest <= 1'b1;
        cyc(1);
        sleepRequest <= 1'b0;
    endtask : sleep

    task automatic restart();
        restartMode <= 1'b1;
        sbcMode <= MODE_NORMAL;
        cyc(2);
        restartMode <= 1'b0;
        check("request cleared", 32'h0000_0000, 32'(restartRequest));
    endtask : restart

    task automatic testReset();
        check("irq idle", 32'h0000_0001, 32'(interrupt_out_n));
        rdchk("status a", OFF_WAKE_STAT_A, 32'hFFFF_FFFF, RESET_VALUE);
        rdchk("status b", OFF_WAKE_STAT_B, 32'hFFFF_FFFF, RESET_VALUE);
        rdchk("unmapped", 8'h1C, 32'hFFFF_FFFF, 32'h0000_0000);
        $display("reset test done");
    endtask : testReset

    // Every on-time code, and every period against the longest on-time.
    task automatic testCodes();
        for (int c = 0; c < 8; c++) begin
            apb(OFF_TIMER_CTRL, 1'b1, (32'(c) << 4) | 32'h0000_000F);
            rdchk("running", OFF_DEV_STAT, 32'h0000_0001, 32'(c >= 1 && c <= 5));
        end
        for (int p = 0; p < 16; p++) begin
            apb(OFF_TIMER_CTRL, 1'b1, 32'h0000_0050 | 32'(p));
            apb(OFF_WAKE_STAT_B, 1'b1, 32'h0000_0001);
            rdchk("on above period", OFF_WAKE_STAT_B, 32'h0000_0001, 32'(p == 0));
        end
        apb(OFF_TIMER_CTRL, 1'b1, 32'h0000_0000);
        $display("code test done");
    endtask : testCodes

    task automatic testWake();
        apb(OFF_WAKE_CTRL, 1'b1, 32'h0000_0002);
        apb(OFF_TIMER_CTRL, 1'b1, 32'h0000_0010);
        watch(PER - 50);
        check("first start irq", 32'h0000_0000, 32'(ints));
        check("switch unassigned", 32'h0000_0000, 32'(hs));
        waitFor(0, 100, "timer irq");
        rdchk("timer flag", OFF_WAKE_STAT_A, 32'h0000_0002, 32'h0000_0002);
        apb(OFF_WAKE_STAT_A, 1'b1, 32'h0000_0002);
        watch(PER - 40);
        check("early irq", 32'h0000_0000, 32'(ints));
        waitFor(0, 100, "next timer irq");
        apb(OFF_TIMER_CTRL, 1'b1, 32'h0000_0000);
        apb(OFF_WAKE_CTRL, 1'b1, 32'h0000_0000);
        apb(OFF_WAKE_STAT_A, 1'b1, 32'h0000_0003);
        $display("wake test done");
    endtask : testWake

    task automatic testSense();
        apb(OFF_WAKE_CTRL, 1'b1, 32'h0000_0031);
        apb(OFF_TIMER_CTRL, 1'b1, 32'h0000_0010);
        waitFor(2, 20, "first window");
        watch(PER - 20);
        check("reference irq", 32'h0000_0000, 32'(ints));
        waitFor(2, 30, "second window");
        watch(3 * TDIV);
        check("on cycles", 32'(TDIV - 1), 32'(hs));
        check("steady irq", 32'h0000_0000, 32'(ints));
        switchClosed <= 1'b1;
        waitFor(0, PER + 100, "sense irq");
        rdchk("wake flag", OFF_WAKE_STAT_A, 32'h0000_0001, 32'h0000_0001);
        rdchk("level", OFF_LEVEL_STAT, 32'h0000_0001, 32'h0000_0001);
        switchClosed <= 1'b0;
        sbcMode <= MODE_STOP;
        waitFor(0, PER + 100, "repeat irq");
        hsOvercurrent <= 1'b1;
        severe_overtemp <= 1'b1;
        watch(PER + 20);
        check("switch in fault", 32'h0000_0000, 32'(hs));
        rdchk("timer kept", OFF_DEV_STAT, 32'h0000_0001, 32'h0000_0001);
        hsOvercurrent <= 1'b0;
        severe_overtemp <= 1'b0;
        apb(OFF_WAKE_STAT_B, 1'b1, 32'h0000_0002);
        $display("sense test done");
    endtask : testSense

    task automatic testSleep();
        sleep();
        waitFor(1, 20, "flagged sleep");
        check("reset out", 32'h0000_0000, 32'(reset_out_n));
        restart();
        rdchk("timer cleared", OFF_DEV_STAT, 32'h0000_0001, 32'h0000_0000);
        apb(OFF_WAKE_STAT_A, 1'b1, 32'h0000_0003);
        apb(OFF_WAKE_STAT_B, 1'b1, 32'h0000_0003);
        sleep();
        waitFor(1, 20, "no valid source");
        restart();
        apb(OFF_TIMER_CTRL, 1'b1, 32'h0000_0010);
        cyc(100);
        sleep();
        cyc(5);
        check("supply off", 32'h0000_0000, 32'(main_supply_out));
        switchClosed <= 1'b1;
        waitFor(1, PER + 100, "sense wake");
        check("supply on", 32'h0000_0001, 32'(main_supply_out));
        restart();
        apb(OFF_TIMER_CTRL, 1'b1, 32'h0000_0010);
        sbcMode <= MODE_FAILSAFE;
        watch(PER + 20);
        check("fail-safe switch", 32'h0000_0000, 32'(hs));
        check("static sense", 32'h0000_0001, 32'(staticSense));
        sbcMode <= MODE_NORMAL;
        $display("sleep test done");
    endtask : testSleep

    // Main sequence.
    initial begin
        cyc(12);
        rst_n <= 1'b1;
        testReset();
        testCodes();
        testWake();
        testSense();
        testSleep();
        tally_and_finish();
    end
endmodule : cyclic_sense_wake_timer_tb
`default_nettype wire
